// ---- logic/sdp_debug_port.sv ----
// Summary of operation
// - After a host falling edge the port waits nine bus ticks and samples the pin.
// - Opcode, address and data move most significant bit first, 16 bus ticks per bit.
// - The bus clock timing the protocol is the system clock divided by two.
// - One pin carries both directions and bit timing restarts on each bit's edge.
// - Memory commands are accepted while user code runs.
// - Accesses use a free bus cycle, or after a bounded wait steal one and stall the CPU.
// - Opcode 90 requests halt only when firmware is enabled, else it is ignored.
// - Opcode E4 takes an address and returns the byte on the low or high half by parity.
// - Opcode EC reads a word in the debug map at a word-aligned address.
// - A byte read of FF01 reports firmware enable and whether background mode is active.
// - Opcode E8 reads a word with the debug map switched out, word aligned.
// - Opcode C4 takes a data byte, ignores its value and sets the status byte's top bit.
`timescale 1ns/1ns
`default_nettype none
module sdp_debug_port
    import sdp_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst_b,
    input  wire logic        ce,
    input  wire logic        pinIn,
    output logic             pinOut,
    output logic             pinOe,
    input  wire logic        busIdle,
    input  wire logic        bgActive,
    output logic             memReq,
    output logic      [15:0] memAddr,
    output logic             memDebugMap,
    input  wire logic        memRdValid,
    input  wire logic [15:0] memRdData,
    output logic             stallCpu,
    output logic             haltReq
);
    sdp_state_type state_q;
    sdp_state_type state_d;
    logic          busTick_q;
    logic          tick;
    logic [15:0]   shift_q;
    logic [4:0]    bitsLeft_q;
    logic [7:0]    opcode_q;
    logic [15:0]   addr_q;
    logic          fwEnable_q;
    logic          haltReq_q;
    logic [3:0]    stealCnt_q;
    logic          stealDue;
    logic          bitDone;
    logic          rxBit;
    logic          lastBit;
    logic          statusHit;
    logic          fifoInValid;
    logic          fifoInReady;
    logic [15:0]   fifoInData;
    logic          fifoOutValid;
    logic          fifoOutReady;
    logic [15:0]   fifoOutData;
    logic [7:0]    statusByte;
    logic [15:0]   rdMasked;

    // ==========================================
    // Bus clock enable at half the system clock
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            busTick_q <= 1'h0;
        end
        else if (ce)
        begin
            busTick_q <= !busTick_q;
        end
    end

    assign tick = busTick_q && ce;

    // ==========================================
    // Serial bit timing and pin drive
    sdp_bit_engine u_bit (
        .mclk    (mclk),
        .rst_b   (rst_b),
        .ce      (ce),
        .busTick (tick),
        .pinIn   (pinIn),
        .pinOut  (pinOut),
        .pinOe   (pinOe),
        .txMode  (state_q == ST_SEND),
        .txBit   (shift_q[DATA_W-1]),
        .bitDone (bitDone),
        .rxBit   (rxBit)
    );

    // ==========================================
    // Read data buffer between memory and shifter
    sdp_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .mclk     (mclk),
        .rst_b    (rst_b),
        .ce       (ce),
        .inValid  (fifoInValid),
        .inReady  (fifoInReady),
        .inData   (fifoInData),
        .outValid (fifoOutValid),
        .outReady (fifoOutReady),
        .outData  (fifoOutData)
    );

    // ==========================================
    // Status byte and read data shaping
    assign statusByte = {fwEnable_q, bgActive, 6'h00};
    assign statusHit  = opcode_q == OP_READ_DBG_BYTE && addr_q == STATUS_ADDR;
    assign rdMasked   = (opcode_q != OP_READ_DBG_BYTE) ? memRdData :
                        addr_q[0] ? {8'h00, memRdData[7:0]} :
                        {memRdData[15:8], 8'h00};
    assign fifoInValid = (state_q == ST_MEM && statusHit)
                         || (state_q == ST_MEMWAIT && memRdValid);
    assign fifoInData  = (state_q == ST_MEM) ? {8'h00, statusByte} : rdMasked;
    assign fifoOutReady = state_q == ST_LOAD;
    assign lastBit      = bitDone && bitsLeft_q == 5'h01;

    // Steal a cycle once the free-cycle wait runs out
    assign stealDue = stealCnt_q == 4'(STEAL_TICKS);
    assign memReq   = state_q == ST_MEM && !statusHit && fifoInReady
                      && tick && (busIdle || stealDue);
    assign stallCpu = memReq && !busIdle;
    assign haltReq  = haltReq_q;

    // ==========================================
    // Command sequencer
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ST_OPCODE:
            begin
                if (lastBit)
                begin
                    if (!rxBit && (shift_q[6:0] == OP_READ_DBG_BYTE[7:1]
                        || shift_q[6:0] == OP_READ_DBG_WORD[7:1]
                        || shift_q[6:0] == OP_READ_WORD[7:1]))
                    begin
                        state_d = ST_ADDR;
                    end
                    else if (shift_q[6:0] == OP_ENABLE_FW[7:1] && !rxBit)
                    begin
                        state_d = ST_WDATA;
                    end
                end
            end
            ST_ADDR:
            begin
                if (lastBit)
                begin
                    state_d = ST_MEM;
                end
            end
            ST_WDATA:
            begin
                if (lastBit)
                begin
                    state_d = ST_OPCODE;
                end
            end
            ST_MEM:
            begin
                if (statusHit && fifoInReady)
                begin
                    state_d = ST_LOAD;
                end
                else if (memReq)
                begin
                    state_d = ST_MEMWAIT;
                end
            end
            ST_MEMWAIT:
            begin
                if (memRdValid)
                begin
                    state_d = ST_LOAD;
                end
            end
            ST_LOAD:
            begin
                if (fifoOutValid)
                begin
                    state_d = ST_SEND;
                end
            end
            default:
            begin
                if (lastBit)
                begin
                    state_d = ST_OPCODE;
                end
            end
        endcase
    end

    // State register
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            state_q <= ST_OPCODE;
        end
        else if (ce)
        begin
            state_q <= state_d;
        end
    end

    // Shift register, most significant bit first both ways
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            shift_q <= 16'h0000;
        end
        else if (ce)
        begin
            if (state_q == ST_LOAD && fifoOutValid)
            begin
                shift_q <= fifoOutData;
            end
            else if (bitDone)
            begin
                shift_q <= {shift_q[14:0], rxBit};
            end
        end
    end

    // Bits remaining in the current field
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            bitsLeft_q <= 5'(OP_W);
        end
        else if (ce)
        begin
            if (lastBit || state_d != state_q)
            begin
                bitsLeft_q <= (state_d == ST_OPCODE || state_d == ST_WDATA)
                              ? 5'(OP_W) : 5'(DATA_W);
            end
            else if (bitDone)
            begin
                bitsLeft_q <= bitsLeft_q - 5'h01;
            end
        end
    end

    // Latch opcode and address as fields complete
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            opcode_q <= 8'h00;
            addr_q   <= 16'h0000;
        end
        else if (ce && lastBit)
        begin
            if (state_q == ST_OPCODE)
            begin
                opcode_q <= {shift_q[6:0], rxBit};
            end
            if (state_q == ST_ADDR)
            begin
                addr_q <= {shift_q[14:0], rxBit};
            end
        end
    end

    // Memory address and map select
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            memAddr     <= 16'h0000;
            memDebugMap <= 1'h1;
        end
        else if (ce && state_q == ST_ADDR && lastBit)
        begin
            memAddr     <= {shift_q[14:0], 1'h0};
            memDebugMap <= opcode_q != OP_READ_WORD;
        end
    end

    // Free-cycle wait counter
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            stealCnt_q <= 4'h0;
        end
        else if (ce)
        begin
            if (state_q != ST_MEM)
            begin
                stealCnt_q <= 4'h0;
            end
            else if (tick && !stealDue)
            begin
                stealCnt_q <= stealCnt_q + 4'h1;
            end
        end
    end

    // Firmware enable and halt request
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            fwEnable_q <= FW_RESET;
            haltReq_q  <= 1'h0;
        end
        else if (ce)
        begin
            haltReq_q <= state_q == ST_OPCODE && lastBit && fwEnable_q
                         && {shift_q[6:0], rxBit} == OP_BACKGROUND;
            if (state_q == ST_WDATA && lastBit)
            begin
                fwEnable_q <= 1'h1;
            end
        end
    end

    // ==========================================
    // Checks
    chk_bus_tick_half : assert property (@(posedge mclk) disable iff (!rst_b)
        (ce && busTick_q) |=> !busTick_q) else $error("bus tick not halved");
    chk_halt_gated : assert property (@(posedge mclk) disable iff (!rst_b)
        haltReq |-> fwEnable_q) else $error("halt without firmware enable");
    chk_fw_set : assert property (@(posedge mclk) disable iff (!rst_b)
        (ce && state_q == ST_WDATA && lastBit) |=> fwEnable_q && state_q == ST_OPCODE)
        else $error("enable write did not set top bit");
    chk_word_align : assert property (@(posedge mclk) disable iff (!rst_b)
        memReq |-> !memAddr[0]) else $error("unaligned memory request");
    chk_normal_map : assert property (@(posedge mclk) disable iff (!rst_b)
        memReq |-> memDebugMap == (opcode_q != OP_READ_WORD))
        else $error("wrong map on read");
    chk_steal_bound : assert property (@(posedge mclk) disable iff (!rst_b)
        stallCpu |-> stealDue && memReq) else $error("cpu stalled before wait ran out");
    chk_msb_first : assert property (@(posedge mclk) disable iff (!rst_b)
        (ce && state_q == ST_LOAD && fifoOutValid) |=> shift_q[15] == $past(fifoOutData[15]))
        else $error("data not sent msb first");
    chk_status_read : assert property (@(posedge mclk) disable iff (!rst_b)
        (ce && state_q == ST_MEM && statusHit && fifoInReady) |-> !memReq
        && fifoInData[7] == fwEnable_q) else $error("status read wrong");

    cov_status_read : cover property (@(posedge mclk) state_q == ST_MEM && statusHit);
    cov_cycle_steal : cover property (@(posedge mclk) stallCpu);
    cov_halt : cover property (@(posedge mclk) haltReq);

endmodule
`default_nettype wire

// ---- logic/sdp_pkg.sv ----
`default_nettype none
package sdp_pkg;

    // ==========================================
    // Serial timing, in bus-clock ticks
    localparam int SAMPLE_TICKS = 9;
    localparam int BIT_TICKS    = 16;
    localparam int DRIVE_TICKS  = BIT_TICKS - 3;  // Pin released before next bit
    localparam int STEAL_TICKS  = 8;              // Wait for a free bus cycle
    localparam int SYS_DIV      = 2;              // System clock to bus clock

    // ==========================================
    // Widths and buffering
    localparam int DATA_W     = 16;
    localparam int OP_W       = 8;
    localparam int FIFO_DEPTH = 32;

    // ==========================================
    // Command opcodes
    localparam logic [7:0] OP_BACKGROUND    = 8'h90;
    localparam logic [7:0] OP_READ_DBG_BYTE = 8'he4;
    localparam logic [7:0] OP_READ_DBG_WORD = 8'hec;
    localparam logic [7:0] OP_READ_WORD     = 8'he8;
    localparam logic [7:0] OP_ENABLE_FW     = 8'hc4;

    // ==========================================
    // Debug status byte
    localparam logic [15:0] STATUS_ADDR   = 16'hff01;
    localparam int          FW_ENABLE_BIT = 7;
    localparam int          BG_ACTIVE_BIT = 6;
    localparam logic        FW_RESET      = 1'h0;

    // ==========================================
    // Command sequencer states
    typedef enum logic [2:0] {
        ST_OPCODE,
        ST_ADDR,
        ST_WDATA,
        ST_MEM,
        ST_MEMWAIT,
        ST_LOAD,
        ST_SEND
    } sdp_state_type;

endpackage
`default_nettype wire

// ---- logic/sdp_fifo.sv ----
`timescale 1ns/1ns
`default_nettype none
module sdp_fifo
    import sdp_pkg::*;
#(
    parameter int WIDTH = DATA_W,
    parameter int DEPTH = FIFO_DEPTH
)
(
    input  wire logic             mclk,
    input  wire logic             rst_b,
    input  wire logic             ce,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr_q;
    logic [AW-1:0]    rdPtr_q;
    logic [AW:0]      count_q;
    logic             push;
    logic             pop;

    // ==========================================
    // Handshake and flags
    assign inReady  = count_q != (AW+1)'(DEPTH);
    assign outValid = count_q != '0;
    assign push     = ce && inValid && inReady;
    assign pop      = ce && outValid && outReady;
    assign outData  = mem[rdPtr_q];

    // Storage
    always_ff @(posedge mclk)
    begin
        if (push)
        begin
            mem[wrPtr_q] <= inData;
        end
    end

    // Pointers and occupancy
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
        end
        else
        begin
            if (push)
            begin
                wrPtr_q <= (wrPtr_q == AW'(DEPTH-1)) ? '0 : wrPtr_q + 1'b1;
            end
            if (pop)
            begin
                rdPtr_q <= (rdPtr_q == AW'(DEPTH-1)) ? '0 : rdPtr_q + 1'b1;
            end
            count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    chk_fifo_no_overrun : assert property (@(posedge mclk) disable iff (!rst_b)
        count_q <= (AW+1)'(DEPTH)) else $error("fifo occupancy above depth");

endmodule
`default_nettype wire

// ---- logic/sdp_bit_engine.sv ----
`timescale 1ns/1ns
`default_nettype none
module sdp_bit_engine
    import sdp_pkg::*;
(
    input  wire logic mclk,
    input  wire logic rst_b,
    input  wire logic ce,
    input  wire logic busTick,
    input  wire logic pinIn,
    output logic      pinOut,
    output logic      pinOe,
    input  wire logic txMode,
    input  wire logic txBit,
    output logic      bitDone,
    output logic      rxBit
);
    logic       pinMeta_q;
    logic       pinSync_q;
    logic       pinPrev_q;
    logic       active_q;
    logic [3:0] tickCnt_q;
    logic       drive_q;
    logic       level_q;
    logic       bitDone_q;
    logic       rxBit_q;
    logic       fallEdge;
    logic       sampleNow;
    logic       windowEnd;

    assign fallEdge  = pinPrev_q && !pinSync_q;
    assign sampleNow = active_q && busTick && tickCnt_q == 4'(SAMPLE_TICKS-1);
    assign windowEnd = active_q && busTick && tickCnt_q == 4'(DRIVE_TICKS-1);
    assign pinOut    = level_q;
    assign pinOe     = drive_q;
    assign bitDone   = bitDone_q;
    assign rxBit     = rxBit_q;

    // ==========================================
    // Pin synchroniser, idles high
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            pinMeta_q <= 1'h1;
            pinSync_q <= 1'h1;
            pinPrev_q <= 1'h1;
        end
        else if (ce)
        begin
            pinMeta_q <= pinIn;
            pinSync_q <= pinMeta_q;
            pinPrev_q <= pinSync_q;
        end
    end

    // Bit window restarts on each host falling edge that arrives while no window is open
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            active_q  <= 1'h0;
            tickCnt_q <= 4'h0;
        end
        else if (ce)
        begin
            if (!active_q && fallEdge)
            begin
                active_q  <= 1'h1;
                tickCnt_q <= 4'h0;
            end
            else if (windowEnd)
            begin
                active_q <= 1'h0;
            end
            else if (active_q && busTick)
            begin
                tickCnt_q <= tickCnt_q + 4'h1;
            end
        end
    end

    // Sample the pin nine bus ticks after the edge
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            bitDone_q <= 1'h0;
            rxBit_q   <= 1'h0;
        end
        else if (ce)
        begin
            bitDone_q <= sampleNow;
            if (sampleNow)
            begin
                rxBit_q <= pinSync_q;
            end
        end
    end

    // Drive the outgoing bit, release before the next one
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            drive_q <= 1'h0;
            level_q <= 1'h1;
        end
        else if (ce)
        begin
            if (!active_q && fallEdge && txMode)
            begin
                drive_q <= 1'h1;
                level_q <= txBit;
            end
            else if (windowEnd)
            begin
                drive_q <= 1'h0;
            end
        end
    end

    chk_sample_point : assert property (@(posedge mclk) disable iff (!rst_b)
        bitDone_q |-> $past(active_q) && $past(tickCnt_q) == 4'(SAMPLE_TICKS-1)
        && $past(busTick)) else $error("bit sampled at wrong tick");
    chk_pin_release : assert property (@(posedge mclk) disable iff (!rst_b)
        (ce && windowEnd) |=> !pinOe ##1 !pinOe) else $error("pin held past window");
    chk_edge_realign : assert property (@(posedge mclk) disable iff (!rst_b)
        (ce && !active_q && fallEdge) |=> active_q && tickCnt_q == 4'h0)
        else $error("bit window not restarted");

endmodule
`default_nettype wire

// ---- verification/sdp_host_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// Debug pod model: opens every bit, pulls the pin up
module sdp_host_model
(
    input  wire logic       mclk,
    input  wire logic       pinOut,
    input  wire logic       pinOe,
    input  wire logic [7:0] gapCycles,
    output logic            pinLevel,
    output logic      [7:0] busyEdges
);
    logic hostLow;

    // Open drain with pull-up, either party pulls low
    assign pinLevel = ~hostLow & (pinOe ? pinOut : 1'b1);

    // Released pin, no late drives seen yet
    initial
    begin
        hostLow   = 1'b0;
        busyEdges = 8'h00;
    end

    // One bit: short low is a one, long low a zero; gap slows the host
    task automatic one_bit(input logic b, output logic s);
        if (pinOe)
            busyEdges++;
        hostLow = 1'b1;
        for (int i = 1; i <= 32 + int'(gapCycles); i++)
        begin
            @(negedge mclk);
            if (i == (b ? 2 : 26))
                hostLow = 1'b0;
            if (i == 22)
                s = pinLevel;
        end
    endtask

    // Field of n bits, most significant first
    task automatic xfer(input logic [15:0] v, input int n, output logic [15:0] r);
        logic s;
        r = 16'h0000;
        for (int i = n - 1; i >= 0; i--)
        begin
            one_bit(v[i], s);
            r[i] = s;
        end
    endtask
endmodule
`default_nettype wire

// ---- verification/sdp_debug_port_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module sdp_debug_port_tb
    import sdp_pkg::*;
;
    logic        mclk;
    logic        rstB;
    logic        pinLevel;
    logic        pinOut;
    logic        pinOe;
    logic        busIdle;
    logic        bgActive;
    logic        memReq;
    logic [15:0] memAddr;
    logic        memDebugMap;
    logic        memRdValid;
    logic [15:0] memRdData;
    logic        stallCpu;
    logic        haltReq;
    logic [7:0]  hostGap;
    logic [7:0]  busyEdges;
    logic        ce;
    logic [15:0] reqAddr;
    logic        reqMap;
    logic        reqStall;
    int          nReq;
    int          pendCnt;
    int          memLat;
    int          haltCount;
    int          nErrors;
    int          checkCount;

    sdp_debug_port sdp_debug_port_inst (.mclk(mclk), .rst_b(rstB), .ce(ce),
        .pinIn(pinLevel), .pinOut(pinOut), .pinOe(pinOe), .busIdle(busIdle),
        .bgActive(bgActive), .memReq(memReq), .memAddr(memAddr),
        .memDebugMap(memDebugMap), .memRdValid(memRdValid), .memRdData(memRdData),
        .stallCpu(stallCpu), .haltReq(haltReq));
    sdp_host_model sdp_host_model_inst (.mclk(mclk), .pinOut(pinOut), .pinOe(pinOe),
        .gapCycles(hostGap), .pinLevel(pinLevel), .busyEdges(busyEdges));

    // ==========================================
    // Clock, memory and halt observers
    always #50 mclk = ~mclk;

    // Record each request and start its answer countdown
    always @(posedge mclk)
    begin
        if (memReq === 1'b1)
        begin
            reqAddr  = memAddr;
            reqMap   = memDebugMap;
            reqStall = stallCpu;
            pendCnt  = memLat;
            nReq++;
        end
        if (haltReq === 1'b1)
            haltCount++;
    end

    // Memory answers after memLat cycles, data derived from the address
    always @(negedge mclk)
    begin
        memRdValid = (pendCnt == 1);
        memRdData  = mem_word(reqAddr);
        if (pendCnt > 0)
            pendCnt--;
    end

    function automatic logic [15:0] mem_word(input logic [15:0] a);
        return {~a[7:0], a[15:8] ^ 8'h3c};
    endfunction

    // ==========================================
    // Shared tasks
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checkCount++;
        if (seen !== exp)
        begin
            nErrors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Opcode, then address and data as the opcode asks
    task automatic run_cmd(input logic [7:0] op, input logic [15:0] a,
                           output logic [15:0] d);
        logic [15:0] x;
        d = 16'h0000;
        sdp_host_model_inst.xfer({8'h00, op}, 8, x);
        if (op == OP_ENABLE_FW)
            sdp_host_model_inst.xfer(a, 8, x);
        else if (op != OP_BACKGROUND)
        begin
            sdp_host_model_inst.xfer(a, 16, x);
            repeat (150) @(negedge mclk);
            sdp_host_model_inst.xfer(16'hffff, 16, d);
        end
        repeat (40) @(negedge mclk);
    endtask

    task automatic end_sim();
        $display("checks %0d errors %0d", checkCount, nErrors);
        if (nErrors == 0 && checkCount > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // ==========================================
    // Scenarios
    task automatic test_word_reads();
        logic [15:0] d;
        run_cmd(OP_READ_DBG_WORD, 16'h1234, d);
        check(d, mem_word(16'h1234));
        check(reqAddr, 16'h1234);
        check({15'h0, reqMap}, 16'h0001);
        check({15'h0, reqStall}, 16'h0000);
        busIdle = 1'b0;
        memLat  = 12;
        hostGap = 8'd20;
        run_cmd(OP_READ_WORD, 16'h4a6f, d);
        check(d, mem_word(16'h4a6e));
        check(reqAddr, 16'h4a6e);
        check({15'h0, reqMap}, 16'h0000);
        check({15'h0, reqStall}, 16'h0001);
        busIdle = 1'b1;
        memLat  = 1;
        hostGap = 8'd0;
    endtask

    task automatic test_byte_reads();
        logic [15:0] d;
        logic [15:0] w;
        w = mem_word(16'h20c2);
        run_cmd(OP_READ_DBG_BYTE, 16'h20c3, d);
        check(d, {8'h00, w[7:0]});
        run_cmd(OP_READ_DBG_BYTE, 16'h20c2, d);
        check(d, {w[15:8], 8'h00});
    endtask

    task automatic test_status_halt();
        logic [15:0] d;
        logic [15:0] st;
        int          n0;
        int          h0;
        n0 = nReq;
        h0 = haltCount;
        run_cmd(OP_READ_DBG_BYTE, STATUS_ADDR, d);
        check(d, 16'h0000);
        st = d;
        run_cmd(OP_BACKGROUND, 16'h0000, d);
        check(16'(haltCount), 16'(h0));
        run_cmd(OP_ENABLE_FW, st | 16'h0080, d);
        run_cmd(OP_READ_DBG_BYTE, STATUS_ADDR, d);
        check(d, 16'h0080);
        bgActive = 1'b1;
        run_cmd(OP_READ_DBG_BYTE, STATUS_ADDR, d);
        check(d, 16'h00c0);
        bgActive = 1'b0;
        run_cmd(OP_BACKGROUND, 16'h0000, d);
        check(16'(haltCount), 16'(h0 + 1));
        check(16'(nReq), 16'(n0));
        rstB = 1'b0;
        repeat (2) @(negedge mclk);
        rstB = 1'b1;
        repeat (5) @(negedge mclk);
        run_cmd(OP_READ_DBG_BYTE, STATUS_ADDR, d);
        check(d, 16'h0000);
    endtask

    // Freeze the port while a stolen read waits, then finish it
    task automatic test_freeze();
        logic [15:0] x;
        logic [15:0] d;
        int          n0;
        n0      = nReq;
        busIdle = 1'b0;
        sdp_host_model_inst.xfer({8'h00, OP_READ_DBG_WORD}, 8, x);
        sdp_host_model_inst.xfer(16'h0ab0, 16, x);
        ce = 1'b0;
        repeat (60) @(negedge mclk);
        check(16'(nReq), 16'(n0));
        ce = 1'b1;
        repeat (150) @(negedge mclk);
        check(16'(nReq), 16'(n0 + 1));
        check({15'h0, reqStall}, 16'h0001);
        busIdle = 1'b1;
        sdp_host_model_inst.xfer(16'hffff, 16, d);
        check(d, mem_word(16'h0ab0));
        repeat (40) @(negedge mclk);
    endtask

    // ==========================================
    // Main sequence and watchdog
    initial
    begin
        mclk = 1'b0; rstB = 1'b0; busIdle = 1'b1; bgActive = 1'b0;
        hostGap = 8'd0; ce = 1'b1;
        memRdValid = 1'b0; memRdData = 16'h0000; reqAddr = 16'h0000;
        reqMap = 1'b0; reqStall = 1'b0; memLat = 1; pendCnt = 0;
        nReq = 0; haltCount = 0; nErrors = 0; checkCount = 0;
        repeat (10) @(negedge mclk);
        rstB = 1'b1;
        repeat (5) @(negedge mclk);
        check({15'h0, pinOe}, 16'h0000);
        check({15'h0, memDebugMap}, 16'h0001);
        test_word_reads();
        test_byte_reads();
        test_status_halt();
        test_freeze();
        check({8'h00, busyEdges}, 16'h0000);
        end_sim();
    end

    initial
    begin
        repeat (60000) @(posedge mclk);
        nErrors++;
        end_sim();
    end
endmodule
`default_nettype wire
